// [rtl/irq_prio_fields.sv]
// priority field register slice with axi4-lite access and winner pick
// What this block does
// - ext irq4 priority in bits 28-26
// - level zero means source disabled
// - ext irq4 subpriority in bits 25-24
// - compare 4 priority in bits 20-18
// - compare 4 subpriority field, levels 0-3
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module irq_prio_fields (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [irq_prio_pkg::DATA_W-1:0] axi_wdata_in,
  input wire logic [irq_prio_pkg::STRB_W-1:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [irq_prio_pkg::DATA_W-1:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic ext_irq4_pend_in,
  input wire logic cmp4_irq_pend_in,
  output logic [irq_prio_pkg::PRIO_W-1:0] ext_irq4_priority_out,
  output logic [irq_prio_pkg::SUB_W-1:0] ext_irq4_subpriority_out,
  output logic [irq_prio_pkg::PRIO_W-1:0] cmp4_irq_priority_out,
  output logic [irq_prio_pkg::SUB_W-1:0] cmp4_irq_subpriority_out,
  output logic grant_valid_out,
  output logic grant_src_out,
  output logic [irq_prio_pkg::PRIO_W-1:0] grant_level_out,
  output logic [irq_prio_pkg::SUB_W-1:0] grant_sub_out
);
  import irq_prio_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    prio_cfg_t ext_cfg;
    prio_cfg_t cmp_cfg;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    arb_res_t grant;
  } slave_state_t;

  localparam slave_state_t STATE_RST = '0;

  slave_state_t state_q;
  slave_state_t state_d;
  arb_res_t pick;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [DATA_W-1:0] rd_word;

  // ----------------------------------------------------------------
  // pick
  // ----------------------------------------------------------------
  irq_pick pick_u (
    .ext_cfg_in(state_q.ext_cfg),
    .cmp_cfg_in(state_q.cmp_cfg),
    .ext_pend_in(ext_irq4_pend_in),
    .cmp_pend_in(cmp4_irq_pend_in),
    .pick_out(pick)
  );

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // one write in flight; new address/data wait until the response leaves
  assign axi_awready_out = !state_q.aw_held && !state_q.bvalid;
  assign axi_wready_out = !state_q.w_held && !state_q.bvalid;
  assign axi_arready_out = !state_q.rvalid;

  assign wr_fire = state_q.aw_held && state_q.w_held && !state_q.bvalid;
  assign wr_hit = state_q.aw_addr[ADDR_W-1:2] == PRIO_REG_OFS[ADDR_W-1:2];
  assign rd_hit = axi_araddr_in[ADDR_W-1:2] == PRIO_REG_OFS[ADDR_W-1:2];

  // reserved positions and the unmodelled low half read as zero
  always_comb begin
    rd_word = '0;
    rd_word[EXT_PRIO_LSB +: PRIO_W] = state_q.ext_cfg.level;
    rd_word[EXT_SUB_LSB +: SUB_W] = state_q.ext_cfg.sub;
    rd_word[CMP_PRIO_LSB +: PRIO_W] = state_q.cmp_cfg.level;
    rd_word[CMP_SUB_LSB +: SUB_W] = state_q.cmp_cfg.sub;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (axi_awvalid_in && axi_awready_out) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out) begin
      state_d.w_held = 1'b1;
      state_d.w_data = axi_wdata_in;
      state_d.w_strb = axi_wstrb_in;
    end
    if (wr_fire) begin
      state_d.aw_held = 1'b0;
      state_d.w_held = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // reserved bits written are dropped, not stored
      if (wr_hit && state_q.w_strb[EXT_LANE]) begin
        state_d.ext_cfg.level =
            state_q.w_data[EXT_PRIO_LSB +: PRIO_W];
        state_d.ext_cfg.sub =
            state_q.w_data[EXT_SUB_LSB +: SUB_W];
      end
      if (wr_hit && state_q.w_strb[CMP_LANE]) begin
        state_d.cmp_cfg.level =
            state_q.w_data[CMP_PRIO_LSB +: PRIO_W];
        state_d.cmp_cfg.sub =
            state_q.w_data[CMP_SUB_LSB +: SUB_W];
      end
    end else if (state_q.bvalid && axi_bready_in) begin
      state_d.bvalid = 1'b0;
    end
    if (axi_arvalid_in && axi_arready_out) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = rd_hit ? rd_word : '0;
      state_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_q.rvalid && axi_rready_in) begin
      state_d.rvalid = 1'b0;
    end
    // registered so the grant outputs carry a glitch-free winner
    state_d.grant = pick;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axi_bvalid_out = state_q.bvalid;
  assign axi_bresp_out = state_q.bresp;
  assign axi_rvalid_out = state_q.rvalid;
  assign axi_rdata_out = state_q.rdata;
  assign axi_rresp_out = state_q.rresp;
  assign ext_irq4_priority_out = state_q.ext_cfg.level;
  assign ext_irq4_subpriority_out = state_q.ext_cfg.sub;
  assign cmp4_irq_priority_out = state_q.cmp_cfg.level;
  assign cmp4_irq_subpriority_out = state_q.cmp_cfg.sub;
  assign grant_valid_out = state_q.grant.valid;
  assign grant_src_out = state_q.grant.src;
  assign grant_level_out = state_q.grant.level;
  assign grant_sub_out = state_q.grant.sub;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ext_level_write: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_fire && wr_hit && state_q.w_strb[EXT_LANE]) |=>
      ext_irq4_priority_out ==
        $past(state_q.w_data[EXT_PRIO_LSB +: PRIO_W]))
    else $error("ext priority not taken from write");

  chk_ext_sub_write: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_fire && wr_hit && state_q.w_strb[EXT_LANE]) |=>
      ext_irq4_subpriority_out ==
        $past(state_q.w_data[EXT_SUB_LSB +: SUB_W]))
    else $error("ext subpriority not taken from write");

  chk_cmp_level_write: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_fire && wr_hit && state_q.w_strb[CMP_LANE]) |=>
      cmp4_irq_priority_out ==
        $past(state_q.w_data[CMP_PRIO_LSB +: PRIO_W]))
    else $error("compare priority not taken from write");

  chk_cmp_sub_write: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_fire && wr_hit && state_q.w_strb[CMP_LANE]) |=>
      cmp4_irq_subpriority_out ==
        $past(state_q.w_data[CMP_SUB_LSB +: SUB_W]))
    else $error("compare subpriority not taken from write");

  chk_off_never_granted: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ext_irq4_priority_out == PRIO_OFF &&
     (!cmp4_irq_pend_in || cmp4_irq_priority_out == PRIO_OFF)) |=>
      !grant_valid_out)
    else $error("disabled source granted");

  chk_level_wins: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ext_irq4_pend_in && cmp4_irq_pend_in &&
     cmp4_irq_priority_out > ext_irq4_priority_out) |=>
      grant_valid_out && grant_src_out == SRC_CMP &&
      grant_level_out == $past(cmp4_irq_priority_out))
    else $error("higher level lost arbitration");

  chk_sub_tiebreak: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ext_irq4_pend_in && cmp4_irq_pend_in &&
     ext_irq4_priority_out != PRIO_OFF &&
     ext_irq4_priority_out == cmp4_irq_priority_out &&
     ext_irq4_subpriority_out > cmp4_irq_subpriority_out) |=>
      grant_valid_out && grant_src_out == SRC_EXT)
    else $error("subpriority tie break wrong");

  // answer one edge after both halves are held; code follows the decode
  chk_write_answer: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_fire |=> axi_bvalid_out &&
      axi_bresp_out == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
    else $error("write answer missing");

endmodule : irq_prio_fields

// [rtl/irq_prio_pkg.sv]
// shared constants and carriers for the priority field slice
package irq_prio_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam logic [ADDR_W-1:0] PRIO_REG_OFS = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PRIO_W = 3;
  localparam int SUB_W = 2;
  localparam int EXT_PRIO_LSB = 26;
  localparam int EXT_SUB_LSB = 24;
  localparam int CMP_PRIO_LSB = 18;
  localparam int CMP_SUB_LSB = 16;
  localparam int EXT_LANE = 3;
  localparam int CMP_LANE = 2;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic [SUB_W-1:0] SUB_RST = 2'h0;

  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  localparam logic SRC_EXT = 1'b0;
  localparam logic SRC_CMP = 1'b1;

  typedef struct packed {
    logic [PRIO_W-1:0] level;
    logic [SUB_W-1:0] sub;
  } prio_cfg_t;

  typedef struct packed {
    logic valid;
    logic src;
    logic [PRIO_W-1:0] level;
    logic [SUB_W-1:0] sub;
  } arb_res_t;

endpackage : irq_prio_pkg

// [rtl/irq_pick.sv]
// two-source priority pick with subpriority tie break
`timescale 1ns/1ps
module irq_pick (
  input wire irq_prio_pkg::prio_cfg_t ext_cfg_in,
  input wire irq_prio_pkg::prio_cfg_t cmp_cfg_in,
  input wire logic ext_pend_in,
  input wire logic cmp_pend_in,
  output irq_prio_pkg::arb_res_t pick_out
);
  import irq_prio_pkg::*;

  logic ext_live;
  logic cmp_live;
  logic cmp_wins;

  // zero level never competes, whatever the subpriority
  assign ext_live = ext_pend_in && (ext_cfg_in.level != PRIO_OFF);
  assign cmp_live = cmp_pend_in && (cmp_cfg_in.level != PRIO_OFF);

  // level first; subpriority only on equal level; full tie keeps ext
  assign cmp_wins = cmp_live && (!ext_live ||
      (cmp_cfg_in.level > ext_cfg_in.level) ||
      ((cmp_cfg_in.level == ext_cfg_in.level) &&
       (cmp_cfg_in.sub > ext_cfg_in.sub)));

  always_comb begin
    pick_out.valid = ext_live || cmp_live;
    pick_out.src = cmp_wins ? SRC_CMP : SRC_EXT;
    pick_out.level = cmp_wins ? cmp_cfg_in.level :
        (ext_live ? ext_cfg_in.level : PRIO_OFF);
    pick_out.sub = cmp_wins ? cmp_cfg_in.sub :
        (ext_live ? ext_cfg_in.sub : SUB_RST);
  end

endmodule : irq_pick

// [bench/tb.sv]
// self-checking bench for the priority field slice
`timescale 1ns/1ps
module tb;
  import irq_prio_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_pend = 1'b0, cmp_pend = 1'b0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd;
  logic [STRB_W-1:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, g_valid, g_src;
  logic [1:0] bresp, rresp, resp;
  logic [PRIO_W-1:0] ext_lvl, cmp_lvl, g_lvl, lv;
  logic [SUB_W-1:0] ext_sub, cmp_sub, g_sub, sv;
  int fails = 0, n_checks = 0, cycles = 0;

  always #10 clk_in = ~clk_in;

  irq_prio_fields u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_wdata_in(wdata),
    .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_bresp_out(bresp),
    .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
    .axi_rready_in(rready), .ext_irq4_pend_in(ext_pend),
    .cmp4_irq_pend_in(cmp_pend), .ext_irq4_priority_out(ext_lvl),
    .ext_irq4_subpriority_out(ext_sub), .cmp4_irq_priority_out(cmp_lvl),
    .cmp4_irq_subpriority_out(cmp_sub), .grant_valid_out(g_valid),
    .grant_src_out(g_src), .grant_level_out(g_lvl),
    .grant_sub_out(g_sub)
  );

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // starts on a fresh edge so strobes never toggle twice in a step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [STRB_W-1:0] s, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_in); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // grant appears one edge after pend and fields are sampled
  task automatic gcase(input logic [PRIO_W-1:0] el, input logic [SUB_W-1:0] es,
                       input logic [PRIO_W-1:0] cl, input logic [SUB_W-1:0] cs,
                       input logic [1:0] p, input logic [6:0] e);
    wr(PRIO_REG_OFS, {3'h0, el, es, 3'h0, cl, cs, 16'h0}, 4'hf, resp);
    @(posedge clk_in);
    ext_pend <= p[1];
    cmp_pend <= p[0];
    repeat (2) @(posedge clk_in);
    `CHK({g_valid, g_src, g_lvl, g_sub}, e)
  endtask : gcase

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // watchdog, generous for a run of under two hundred cycles
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("ERROR t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h0)
    rd_reg(PRIO_REG_OFS, rd, resp);
    `CHK(rd, 32'h0)
    // every level and subpriority code on both sources
    for (int i = 0; i < 8; i++) begin
      lv = i[2:0];
      sv = i[1:0];
      // reserved bits zero; low-half fields belong elsewhere and drop
      wr(PRIO_REG_OFS, {3'h0, lv, sv, 3'h0, ~lv, ~sv, 16'h1f1f}, 4'hf,
         resp);
      `CHK(resp, RESP_OKAY)
      `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, {lv, sv, ~lv, ~sv})
      rd_reg(PRIO_REG_OFS, rd, resp);
      `CHK(rd, {3'h0, lv, sv, 3'h0, ~lv, ~sv, 16'h0})
    end
    // byte lanes reach only their own source
    wr(PRIO_REG_OFS, 32'h1f1f0000, 4'h4, resp);
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h3ff)
    wr(PRIO_REG_OFS, 32'h0, 4'h8, resp);
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h01f)
    // unmapped word: error answer, fields untouched
    wr(8'h04, 32'hffffffff, 4'hf, resp);
    `CHK(resp, RESP_SLVERR)
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h01f)
    rd_reg(8'h04, rd, resp);
    `CHK({rd, resp}, {32'h0, RESP_SLVERR})
    // arbitration: level, tie break, disabled and idle sources
    gcase(3'h5, 2'h1, 3'h3, 2'h3, 2'h3, 7'h55);
    gcase(3'h2, 2'h0, 3'h6, 2'h0, 2'h3, 7'h78);
    gcase(3'h4, 2'h1, 3'h4, 2'h2, 2'h3, 7'h72);
    gcase(3'h4, 2'h2, 3'h4, 2'h2, 2'h3, 7'h52);
    gcase(3'h4, 2'h3, 3'h4, 2'h1, 2'h3, 7'h53);
    gcase(3'h0, 2'h3, 3'h1, 2'h0, 2'h3, 7'h64);
    gcase(3'h0, 2'h3, 3'h0, 2'h0, 2'h3, 7'h00);
    gcase(3'h7, 2'h0, 3'h1, 2'h0, 2'h1, 7'h64);
    gcase(3'h7, 2'h0, 3'h1, 2'h0, 2'h0, 7'h00);
    // mid-run reset clears every field again
    wr(PRIO_REG_OFS, 32'h1f1f0000, 4'hf, resp);
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h3ff)
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    `CHK({ext_lvl, ext_sub, cmp_lvl, cmp_sub}, 10'h0)
    rd_reg(PRIO_REG_OFS, rd, resp);
    `CHK({rd, resp}, {32'h0, RESP_OKAY})
    tally_and_finish();
  end
endmodule : tb
